// ### logic/ltr_ldo_regs.sv
// ltr_ldo_regs: serial-bus register bank for three ldo regulators
// assumes: scl/sda and below-threshold levels arrive from outside the clock domain
// Functional notes
// R1: 43h bit4 is third ldo discharge enable
// R2: 43h bits 7:5 read power good flags
// R3: power good clears while output below threshold
// R4: 5-bit code, range bits 4:3, step 2:0
// R5: code decodes to documented millivolt table
// R6: each enable bit drives only its ldo
// R7: discharge switch on when enabled and ldo off
// R8: host writes write-exact bit1 only as default
// R9: read-only bits ignore writes, fixed values except the 43h bits 7:5 power good flags
// R10: written values reach outputs right after byte
`default_nettype none
`include "ltr_map.svh"

module ltr_ldo_regs
    import ltr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // value arbitrary
    parameter logic [5:0] RO_HI = 6'h00,
    parameter logic RO_LSB = 1'h0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] below_thr_i,
    output var logic sda_o,
    output var logic sda_oe_o,
    output var logic [2:0] ldo_enable_o,
    output var logic [2:0][4:0] ldo_voltage_code_o,
    output var logic [2:0][11:0] ldo_vout_mv_o,
    output var logic [2:0] ldo_discharge_on_o,
    output var logic [2:0] ldo_power_good_o
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [2:0] reg_idx(input logic [7:0] p);
        if (p == `LTR_OFS_FIRST) begin
            return 3'h0;
        end else if (p == `LTR_OFS_SECOND) begin
            return 3'h1;
        end else if (p == `LTR_OFS_THIRD) begin
            return 3'h2;
        end else if (p == `LTR_OFS_STATUS) begin
            return 3'h3;
        end else begin
            return 3'h4;
        end
    endfunction

    function automatic ltr_mv_t vmv(input ltr_code_t c);
        ltr_mv_t st;
        st = {9'h000, c[2:0]};
        case (c[4:3]) // see R5
            2'h0: return `LTR_MV_BASE0 + 12'(st * `LTR_MV_COARSE);
            2'h1: return `LTR_MV_BASE1 + 12'(st * `LTR_MV_FINE);
            2'h2: return `LTR_MV_BASE2 + 12'(st * `LTR_MV_FINE);
            default: return `LTR_MV_BASE3 + 12'(st * `LTR_MV_COARSE);
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    ltr_sync_if #(.W(5)) sif ();
    assign sif.raw = {below_thr_i, sda_i, scl_i};
    ltr_sync #(.W(5), .RST_VAL(`LTR_SYNC_RST)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .sif(sif.sync_mp)
    );
    logic scl_s, sda_s;
    logic [2:0] below_s;
    assign scl_s = sif.clean[0];
    assign sda_s = sif.clean[1];
    assign below_s = sif.clean[4:2];

    // ----------------------------------------
    // state
    // ----------------------------------------
    ltr_state_t state, next_state;
    logic scl_q, sda_q, got8, next_got8, rw, next_rw, nack, next_nack, next_oe;
    logic [2:0] cnt, next_cnt, dis, next_dis, next_en;
    logic [7:0] shreg, next_shreg, ptr, next_ptr, rd_now;
    logic [2:0][4:0] next_code;
    logic we_bit, next_we, wr_stb;
    logic [2:0] wr_idx;
    logic scl_rise, scl_fall, start_det, stop_det;

    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_det = scl_s && scl_q && sda_q && !sda_s;
    assign stop_det = scl_s && scl_q && !sda_q && sda_s;
    assign wr_idx = reg_idx(ptr);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        logic [2:0] ri;
        ri = reg_idx(ptr);
        rd_now = `LTR_RST_BYTE;
        if (ri < 3'h3) begin // see R9
            rd_now = {RO_HI[2*ri[1:0] +: 2], ldo_enable_o[ri[1:0]], ldo_voltage_code_o[ri[1:0]]};
        end else if (ri == 3'h3) begin // see R2
            rd_now = {ldo_power_good_o[2], ldo_power_good_o[1], ldo_power_good_o[0],
                      dis, we_bit, RO_LSB};
        end
    end

    // ----------------------------------------
    // serial engine and register writes
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_cnt = cnt;
        next_got8 = got8;
        next_rw = rw;
        next_nack = nack;
        next_ptr = ptr;
        next_oe = sda_oe_o;
        next_en = ldo_enable_o;
        next_code = ldo_voltage_code_o;
        next_dis = dis;
        next_we = we_bit;
        wr_stb = 1'b0;
        if (stop_det) begin
            next_state = LTR_IDLE;
            next_oe = 1'b0;
        end else if (start_det) begin
            next_state = LTR_ADDR;
            next_cnt = `LTR_RST_CNT;
            next_got8 = 1'b0;
            next_oe = 1'b0;
        end else begin
            case (state)
                LTR_ADDR, LTR_REG, LTR_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_cnt = cnt + 3'h1;
                        next_got8 = (cnt == `LTR_CNT_LAST);
                    end else if (scl_fall && got8) begin
                        next_got8 = 1'b0;
                        next_oe = 1'b1;
                        if (state == LTR_ADDR) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                next_rw = shreg[0];
                                next_state = LTR_ACK_ADDR;
                            end else begin
                                next_oe = 1'b0;
                                next_state = LTR_IDLE;
                            end
                        end else if (state == LTR_REG) begin
                            next_ptr = shreg;
                            next_state = LTR_ACK_REG;
                        end else begin
                            wr_stb = 1'b1; // see R10
                            next_ptr = ptr + 8'h01;
                            next_state = LTR_ACK_DATA;
                        end
                    end
                end
                LTR_ACK_ADDR, LTR_ACK_REG, LTR_ACK_DATA: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_cnt = `LTR_RST_CNT;
                        if (state == LTR_ACK_ADDR && rw) begin
                            next_shreg = rd_now;
                            next_oe = !rd_now[7];
                            next_state = LTR_RDATA;
                        end else if (state == LTR_ACK_ADDR) begin
                            next_state = LTR_REG;
                        end else begin
                            next_state = LTR_WDATA;
                        end
                    end
                end
                LTR_RDATA: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 3'h1;
                        next_got8 = (cnt == `LTR_CNT_LAST);
                    end else if (scl_fall && got8) begin
                        next_got8 = 1'b0;
                        next_oe = 1'b0;
                        next_ptr = ptr + 8'h01;
                        next_state = LTR_RACK;
                    end else if (scl_fall) begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe = !shreg[6];
                    end
                end
                LTR_RACK: begin
                    if (scl_rise) begin
                        next_nack = sda_s;
                    end else if (scl_fall && nack) begin
                        next_state = LTR_IDLE;
                    end else if (scl_fall) begin
                        next_shreg = rd_now;
                        next_oe = !rd_now[7];
                        next_cnt = `LTR_RST_CNT;
                        next_state = LTR_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wr_stb && wr_idx < 3'h3) begin
            next_en[wr_idx[1:0]] = shreg[`LTR_EN_BIT]; // see R6
            next_code[wr_idx[1:0]] = shreg[`LTR_CODE_MSB:0]; // see R4
        end else if (wr_stb && wr_idx == 3'h3) begin
            next_dis = shreg[`LTR_DIS_MSB:`LTR_DIS_LSB]; // see R1
            next_we = shreg[`LTR_WE_BIT];
        end
    end

    // ----------------------------------------
    // derived outputs
    // ----------------------------------------
    logic [2:0] next_pg, next_dchg;
    logic [2:0][11:0] next_mv;
    always_comb begin
        next_pg = ~below_s; // see R3
        next_dchg = dis & ~ldo_enable_o; // see R7
        for (int i = 0; i < 3; i++) begin
            next_mv[i] = vmv(ldo_voltage_code_o[i]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= LTR_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            shreg <= `LTR_RST_BYTE;
            cnt <= `LTR_RST_CNT;
            got8 <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            ptr <= `LTR_RST_BYTE;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
            ldo_enable_o <= `LTR_RST_BITS3;
            ldo_voltage_code_o <= {3{`LTR_RST_CODE}};
            dis <= `LTR_RST_BITS3;
            we_bit <= `LTR_RST_BIT;
            ldo_power_good_o <= `LTR_RST_BITS3;
            ldo_discharge_on_o <= `LTR_RST_BITS3;
            ldo_vout_mv_o <= {3{`LTR_MV_BASE0}};
        end else begin
            state <= next_state;
            scl_q <= scl_s;
            sda_q <= sda_s;
            shreg <= next_shreg;
            cnt <= next_cnt;
            got8 <= next_got8;
            rw <= next_rw;
            nack <= next_nack;
            ptr <= next_ptr;
            sda_oe_o <= next_oe;
            sda_o <= 1'b0;
            ldo_enable_o <= next_en;
            ldo_voltage_code_o <= next_code;
            dis <= next_dis;
            we_bit <= next_we;
            ldo_power_good_o <= next_pg;
            ldo_discharge_on_o <= next_dchg;
            ldo_vout_mv_o <= next_mv;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_r1;
        wr_stb && wr_idx == 3'h3 |=> dis[2] == $past(shreg[4]);
    endproperty
    a_r1: assert property (p_r1) else $error("discharge enable not stored"); // see R1
    property p_r2;
        state == LTR_ACK_ADDR && rw && scl_fall && reg_idx(ptr) == 3'h3
            |=> shreg[7:5] == $past(ldo_power_good_o);
    endproperty
    a_r2: assert property (p_r2) else $error("power good readback wrong"); // see R2
    property p_r3;
        below_s != 3'h0 |=> (ldo_power_good_o & $past(below_s)) == 3'h0;
    endproperty
    a_r3: assert property (p_r3) else $error("power good not cleared"); // see R3
    property p_r4;
        wr_stb && wr_idx == 3'h0 |=> ldo_voltage_code_o[0] == $past(shreg[4:0]);
    endproperty
    a_r4: assert property (p_r4) else $error("voltage code not stored"); // see R4
    property p_r5;
        ldo_voltage_code_o[1][4:3] == 2'h1 ##1 $stable(ldo_voltage_code_o[1])
            |-> ldo_vout_mv_o[1] == 12'h866 + 12'(12'h032 * ldo_voltage_code_o[1][2:0]);
    endproperty
    a_r5: assert property (p_r5) else $error("voltage decode wrong"); // see R5
    property p_r6;
        wr_stb && wr_idx == 3'h1 |=> $stable(ldo_enable_o[0]) && $stable(ldo_enable_o[2]);
    endproperty
    a_r6: assert property (p_r6) else $error("enable crosstalk"); // see R6
    property p_r7;
        ##1 ldo_discharge_on_o == $past(dis & ~ldo_enable_o);
    endproperty
    a_r7: assert property (p_r7) else $error("discharge switch wrong"); // see R7
    property p_r9;
        state == LTR_ACK_ADDR && rw && scl_fall && reg_idx(ptr) == 3'h3
            |=> shreg[0] == RO_LSB;
    endproperty
    a_r9: assert property (p_r9) else $error("read-only bit changed"); // see R9
    property p_r10;
        wr_stb && wr_idx == 3'h2 |=> ldo_enable_o[2] == $past(shreg[5]);
    endproperty
    a_r10: assert property (p_r10) else $error("enable not forwarded"); // see R10

    c_write: cover property (wr_stb);
    c_read: cover property (state == LTR_RDATA && scl_fall && got8);
    c_dchg: cover property (ldo_discharge_on_o != 3'h0);
endmodule

`default_nettype wire

// ### logic/ltr_map.svh
// ltr_map.svh: register offsets, field positions, reset values and decode constants
// assumes: included by the ldo control bank files after the package
`ifndef LTR_MAP_SVH
`define LTR_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LTR_OFS_FIRST 8'h40
`define LTR_OFS_SECOND 8'h41
`define LTR_OFS_THIRD 8'h42
`define LTR_OFS_STATUS 8'h43

// ----------------------------------------
// field positions
// ----------------------------------------
`define LTR_EN_BIT 5
`define LTR_CODE_MSB 4
`define LTR_DIS_LSB 2
`define LTR_DIS_MSB 4
`define LTR_WE_BIT 1
`define LTR_PG_LSB 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define LTR_RST_CODE 5'h00
`define LTR_RST_BITS3 3'h0
`define LTR_RST_BIT 1'h0
`define LTR_RST_BYTE 8'h00
`define LTR_RST_CNT 3'h0
`define LTR_CNT_LAST 3'h7
`define LTR_SYNC_RST 5'h1f

// ----------------------------------------
// voltage decode in millivolts
// ----------------------------------------
`define LTR_MV_BASE0 12'h578
`define LTR_MV_BASE1 12'h866
`define LTR_MV_BASE2 12'h9f6
`define LTR_MV_BASE3 12'hbb8
`define LTR_MV_COARSE 12'h064
`define LTR_MV_FINE 12'h032

`endif

// ### logic/ltr_pkg.sv
// ltr_pkg: types of the ldo control bank
// assumes: nothing beyond a sv compiler
`default_nettype none

package ltr_pkg;
    typedef logic [4:0] ltr_code_t;
    typedef logic [11:0] ltr_mv_t;
    typedef enum logic [3:0] {
        LTR_IDLE,
        LTR_ADDR,
        LTR_ACK_ADDR,
        LTR_REG,
        LTR_ACK_REG,
        LTR_WDATA,
        LTR_ACK_DATA,
        LTR_RDATA,
        LTR_RACK
    } ltr_state_t;
endpackage

`default_nettype wire

// ### logic/ltr_sync_if.sv
// ltr_sync_if: raw pin levels in, agreed levels out
// assumes: one clock domain, driven by ltr_sync
`default_nettype none

interface ltr_sync_if #(parameter int W = 5);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync_mp(input raw, output clean);
    modport user_mp(output raw, input clean);
endinterface

`default_nettype wire

// ### logic/ltr_sync.sv
// ltr_sync: three-stage pin synchroniser, output moves when stages two and three agree
// assumes: clk_i domain, synchronous active-high reset
`default_nettype none
`include "ltr_map.svh"

module ltr_sync
    import ltr_pkg::*;
#(
    parameter int W = 5,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    ltr_sync_if.sync_mp sif
);
    logic [W-1:0] s1, s2, s3, clean;
    logic [W-1:0] next_clean;

    // ----------------------------------------
    // per-bit agreement filter
    // ----------------------------------------
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_comb begin
            next_clean[g] = (s2[g] == s3[g]) ? s3[g] : clean[g];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            clean <= RST_VAL;
        end else begin
            s1 <= sif.raw;
            s2 <= s1;
            s3 <= s2;
            clean <= next_clean;
        end
    end

    assign sif.clean = clean;
endmodule

`default_nettype wire

// ### dv/ltr_host.sv
// ltr_host: serial-bus host model, drives scl and pulls sda low
// assumes: sda_i is the wired level with a pull-up; changes land at falling clk edges
`default_nettype none

module ltr_host #(
    parameter int HALF = 8
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // ----------------------------------------
    // bus phases
    // ----------------------------------------
    task automatic hold();
        repeat (HALF) @(negedge clk_i);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_pull_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_pull_o = 1'b1;
        hold();
        scl_o = 1'b0;
        hold();
    endtask

    task automatic stop();
        sda_pull_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_pull_o = 1'b0;
        hold();
    endtask

    // data is set HALF clk cycles (a third of the bit period) before the rise and sampled at the end of the high phase
    task automatic clk_bit(input logic b, output logic seen);
        sda_pull_o = ~b;
        hold();
        scl_o = 1'b1;
        hold();
        seen = sda_i;
        scl_o = 1'b0;
        hold();
    endtask

    task automatic tx(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask

    // last = 1 answers with a nack
    task automatic rx(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(last, s);
    endtask
endmodule

`default_nettype wire

// ### dv/ltr_ldo_regs_tb.sv
// ltr_ldo_regs_tb: register bank bench through the serial host model
// assumes: ltr_pkg, ltr_sync and ltr_ldo_regs compiled before this file
`default_nettype none

`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
end

module ltr_ldo_regs_tb
    import ltr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] DEV = 7'h2a; // value arbitrary
    logic clk_i;
    logic srst_i;
    logic [2:0] below_thr_i;
    logic scl;
    logic sda_pull;
    logic sda_o;
    logic sda_oe_o;
    wire logic sda_w;
    logic [2:0] ldo_enable_o;
    logic [2:0][4:0] ldo_voltage_code_o;
    logic [2:0][11:0] ldo_vout_mv_o;
    logic [2:0] ldo_discharge_on_o;
    logic [2:0] ldo_power_good_o;
    logic [7:0] got [4];
    int num_errors = 0;
    int num_checks = 0;

    // wired level: pull-up unless either side pulls low
    assign sda_w = ~(sda_pull | (sda_oe_o & ~sda_o));

    ltr_ldo_regs #(.DEV_ADDR(DEV)) dut (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .scl_i(scl),
        .sda_i(sda_w),
        .below_thr_i(below_thr_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .ldo_enable_o(ldo_enable_o),
        .ldo_voltage_code_o(ldo_voltage_code_o),
        .ldo_vout_mv_o(ldo_vout_mv_o),
        .ldo_discharge_on_o(ldo_discharge_on_o),
        .ldo_power_good_o(ldo_power_good_o)
    );

    ltr_host #(.HALF(8)) host (
        .clk_i(clk_i),
        .sda_i(sda_w),
        .scl_o(scl),
        .sda_pull_o(sda_pull)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [11:0] mv_of(input logic [4:0] c);
        case (c[4:3])
            2'b00: return 12'h578 + 12'h064 * c[2:0];
            2'b01: return 12'h866 + 12'h032 * c[2:0];
            2'b10: return 12'h9f6 + 12'h032 * c[2:0];
            default: return 12'hbb8 + 12'h064 * c[2:0];
        endcase
    endfunction

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic a0, a1, a2;
        host.start();
        host.tx({DEV, 1'b0}, a0);
        host.tx(ofs, a1);
        host.tx(d, a2);
        host.stop();
        `CHK("write acks", 3'b111, ({a0, a1, a2}))
    endtask

    task automatic rd(input logic [7:0] ofs, input int n);
        logic a0, a1, a2;
        host.start();
        host.tx({DEV, 1'b0}, a0);
        host.tx(ofs, a1);
        host.start();
        host.tx({DEV, 1'b1}, a2);
        for (int k = 0; k < n; k++) begin
            host.rx(k == n - 1, got[k]);
        end
        host.stop();
        `CHK("read acks", 3'b111, ({a0, a1, a2}))
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int i;
        logic a;
        logic [2:0] m;
        srst_i = 1'b1;
        below_thr_i = 3'b000;
        repeat (10) @(negedge clk_i);
        `CHK("en rst", 3'b000, ldo_enable_o)
        `CHK("code rst", 15'h0000, ldo_voltage_code_o)
        `CHK("mv rst", ({3{12'h578}}), ldo_vout_mv_o)
        `CHK("dis rst", 3'b000, ldo_discharge_on_o)
        `CHK("pg rst", 3'b000, ldo_power_good_o)
        srst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        `CHK("pg up", 3'b111, ldo_power_good_o)
        rd(8'h40, 4);
        for (int k = 0; k < 4; k++) begin
            `CHK("rst byte", (k == 3) ? 8'he0 : 8'h00, got[k])
        end
        host.start();
        host.tx({DEV ^ 7'h01, 1'b0}, a);
        host.stop();
        `CHK("foreign addr ack", 1'b0, a)
        for (int c = 0; c < 32; c++) begin
            i = c % 3;
            wr(8'h40 + 8'(i), {3'b110, 5'(c)});
            `CHK("code", 5'(c), ldo_voltage_code_o[i])
            `CHK("mv", mv_of(5'(c)), ldo_vout_mv_o[i])
            `CHK("en ro", 3'b000, ldo_enable_o)
        end
        rd(8'h40, 3);
        `CHK("byte 40", 8'h1e, got[0])
        `CHK("byte 41", 8'h1f, got[1])
        `CHK("byte 42", 8'h1d, got[2])
        rd(8'h50, 1);
        `CHK("unmapped", 8'h00, got[0])
        wr(8'h43, 8'h1d);
        rd(8'h43, 1);
        `CHK("byte 43", 8'hfc, got[0])
        `CHK("dis all", 3'b111, ldo_discharge_on_o)
        for (int k = 0; k < 3; k++) begin
            wr(8'h40 + 8'(k), 8'h20);
            m = 3'((1 << (k + 1)) - 1);
            `CHK("en step", m, ldo_enable_o)
            `CHK("dis step", ~m, ldo_discharge_on_o)
        end
        wr(8'h41, 8'h00);
        `CHK("en mid off", 3'b101, ldo_enable_o)
        `CHK("dis mid", 3'b010, ldo_discharge_on_o)
        wr(8'h43, 8'h10);
        `CHK("dis third only", 3'b000, ldo_discharge_on_o)
        wr(8'h42, 8'h00);
        `CHK("en third off", 3'b001, ldo_enable_o)
        `CHK("dis third", 3'b100, ldo_discharge_on_o)
        rd(8'h43, 1);
        `CHK("byte 43 b", 8'hf0, got[0])
        below_thr_i = 3'b101;
        repeat (10) @(negedge clk_i);
        `CHK("pg low", 3'b010, ldo_power_good_o)
        rd(8'h43, 1);
        `CHK("byte 43 pg", 8'h50, got[0])
        report_and_stop();
    end
endmodule

`default_nettype wire
